// ==== verilog/sdmc_supply_drop_monitor_ctl.sv ====
/*
 * Control logic of the supply drop monitor: configuration, reset request
 * with hysteresis and the low supply status flag.
 * Assumes analog comparator outputs arrive asynchronously and that the
 * system reset controller returns its reset level on sys_reset.
 */
// Function
// - Monitor is enabled straight out of reset, no software needed.
// - Comparator is used only while power-disable is clear.
// - Falling below selected trip level requests reset unless reset-disable.
// - Stop mode keeps monitor on only if power enabled and stop-enable set.
// - Trip select 1 picks high detect level, 0 low; reset picks low.
// - Raising trip level while supply under it resets after the settle time.
// - Reset request holds until supply rises above rising threshold.
// - Flag sets below falling, clears above rising, otherwise holds.
// - Any reset clears the flag; flag cannot be written.
// - Monitor never raises an interrupt.
// - Reset-disable and trip select rewritable; other settings write-once.
// - Monitor stays active in wait mode and can reset from it.
`timescale 1ns/100ps
`default_nettype none
module sdmc_supply_drop_monitor_ctl (
    input wire logic clk,
    input wire logic rst,
    input wire logic sys_reset,
    input wire logic cfg_wr,
    input wire sdmc_pkg::sdmc_cfg_s cfg_wdata,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire sdmc_pkg::sdmc_cmp_s cmp_async,
    output sdmc_pkg::sdmc_cfg_s cfg_rdata,
    output logic cfg_locked,
    output logic low_supply_flag,
    output logic monitor_reset_req,
    output logic monitor_analog_en,
    output logic trip_level_out,
    output logic monitor_irq
);
    import sdmc_pkg::*;

    typedef struct packed {
        sdmc_cmp_s sync1;
        sdmc_cmp_s sync2;
        sdmc_cfg_s cfg;
        logic locked;
        sdmc_state_e state;
        logic [3:0] settle;
        logic flag;
        logic req;
        logic analog_en;
        logic level;
        logic irq;
    } sdmc_st_s;

    sdmc_st_s st_ff;
    sdmc_st_s nxt_st;
    logic active;
    logic below_s;
    logic above_s;
    logic resets_on;

    // Stop mode needs its own enable; run and wait only need power
    always_comb
    begin
        active = !st_ff.cfg.monitor_power_disable;
        if (stop_mode)
        begin
            active = active && st_ff.cfg.monitor_stop_enable;
        end
        // Disabled monitor looks like a healthy supply
        below_s = active && st_ff.sync2.below_fall;
        above_s = !active || st_ff.sync2.above_rise;
        resets_on = active && !st_ff.cfg.monitor_reset_disable;
    end

    always_comb
    begin
        nxt_st = st_ff;
        // Only the second stage is read; the first may be metastable
        nxt_st.sync1 = cmp_async;
        nxt_st.sync2 = st_ff.sync1;

        if (cfg_wr)
        begin
            // Only the reset and level fields stay writable after lock
            nxt_st.cfg.monitor_reset_disable =
                cfg_wdata.monitor_reset_disable;
            nxt_st.cfg.trip_level_select = cfg_wdata.trip_level_select;
            if (!st_ff.locked)
            begin
                nxt_st.cfg.monitor_power_disable =
                    cfg_wdata.monitor_power_disable;
                nxt_st.cfg.monitor_stop_enable =
                    cfg_wdata.monitor_stop_enable;
                nxt_st.locked = 1'h1;
            end
        end

        case (st_ff.state)
            SDMC_NORMAL:
            begin
                nxt_st.settle = 4'h0;
                if (resets_on && below_s)
                begin
                    nxt_st.state = SDMC_RESET;
                end
                else if (cfg_wr && st_ff.level == LEVEL_LOW_RESET &&
                    cfg_wdata.trip_level_select == LEVEL_HIGH_DETECT)
                begin
                    nxt_st.state = SDMC_CHECK;
                end
            end
            SDMC_CHECK:
            begin
                // First readings still reflect the old level: wait for
                // the settle time and both sync stages before deciding
                nxt_st.settle = st_ff.settle + 4'h1;
                if (resets_on && below_s)
                begin
                    nxt_st.state = SDMC_RESET;
                end
                else if (st_ff.level != LEVEL_HIGH_DETECT)
                begin
                    nxt_st.state = SDMC_NORMAL;
                end
                else if (st_ff.settle >= SETTLE_CYC + 4'h1)
                begin
                    if (resets_on && !above_s)
                    begin
                        nxt_st.state = SDMC_RESET;
                    end
                    else
                    begin
                        nxt_st.state = SDMC_NORMAL;
                    end
                end
            end
            SDMC_RESET:
            begin
                nxt_st.settle = 4'h0;
                if (above_s && !below_s)
                begin
                    nxt_st.state = SDMC_NORMAL;
                end
            end
            default:
            begin
                nxt_st.state = SDMC_NORMAL;
                nxt_st.settle = 4'h0;
            end
        endcase
        nxt_st.req = (nxt_st.state == SDMC_RESET);

        // Reset clear wins; the request itself must outlive sys_reset
        if (sys_reset)
        begin
            nxt_st.flag = 1'h0;
        end
        else if (below_s)
        begin
            nxt_st.flag = 1'h1;
        end
        else if (above_s)
        begin
            nxt_st.flag = 1'h0;
        end

        nxt_st.analog_en = active;
        nxt_st.level = nxt_st.cfg.trip_level_select;
        nxt_st.irq = 1'h0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff.sync1 <= '{below_fall: 1'h0, above_rise: 1'h1};
            st_ff.sync2 <= '{below_fall: 1'h0, above_rise: 1'h1};
            st_ff.cfg.monitor_power_disable <= RST_POWER_DISABLE;
            st_ff.cfg.monitor_stop_enable <= RST_STOP_ENABLE;
            st_ff.cfg.monitor_reset_disable <= RST_RESET_DISABLE;
            st_ff.cfg.trip_level_select <= RST_TRIP_LEVEL;
            st_ff.locked <= 1'h0;
            st_ff.state <= SDMC_NORMAL;
            st_ff.settle <= 4'h0;
            st_ff.flag <= 1'h0;
            st_ff.req <= 1'h0;
            st_ff.analog_en <= !RST_POWER_DISABLE;
            st_ff.level <= RST_TRIP_LEVEL;
            st_ff.irq <= 1'h0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cfg_rdata = st_ff.cfg;
    assign cfg_locked = st_ff.locked;
    assign low_supply_flag = st_ff.flag;
    assign monitor_reset_req = st_ff.req;
    assign monitor_analog_en = st_ff.analog_en;
    assign trip_level_out = st_ff.level;
    assign monitor_irq = st_ff.irq;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Enable, power and low-power modes
    AST_ENABLED_AFTER_RESET: assert property (
        $fell(rst) |-> monitor_analog_en && !cfg_rdata.monitor_power_disable)
        else $error("monitor not enabled after reset");
    AST_POWER_OFF: assert property (
        cfg_rdata.monitor_power_disable |=> !monitor_analog_en)
        else $error("monitor powered while disabled");
    AST_ANALOG_ON: assert property (
        !cfg_rdata.monitor_power_disable && !stop_mode |=> monitor_analog_en)
        else $error("monitor off while enabled");
    AST_STOP_GATE: assert property (
        stop_mode && !cfg_rdata.monitor_stop_enable |=> !monitor_analog_en)
        else $error("monitor active in stop without enable");
    AST_STOP_ACTIVE: assert property (
        stop_mode && cfg_rdata.monitor_stop_enable &&
            !cfg_rdata.monitor_power_disable |=> monitor_analog_en)
        else $error("monitor off in stop though enabled");
    AST_WAIT_ACTIVE: assert property (
        wait_mode && !stop_mode && !cfg_rdata.monitor_power_disable |=>
            monitor_analog_en)
        else $error("monitor inactive in wait");

    // Reset request
    AST_TRIP_RESET: assert property (
        resets_on && below_s |=> monitor_reset_req)
        else $error("no reset request on low supply");
    AST_NO_REQ_DISABLED: assert property (
        !monitor_reset_req && !resets_on |=> !monitor_reset_req)
        else $error("reset requested while resets disabled");
    AST_RAISE_RESET: assert property (
        (st_ff.state == SDMC_CHECK && resets_on && !above_s &&
         trip_level_out) [*7] |=> monitor_reset_req)
        else $error("raised level under supply did not reset");
    AST_CHECK_ENDS: assert property (
        st_ff.state == SDMC_CHECK |-> ##[1:8] st_ff.state != SDMC_CHECK)
        else $error("level raise check never finished");
    AST_HOLD_REQ: assert property (
        monitor_reset_req && !above_s |=> monitor_reset_req)
        else $error("reset released before supply recovered");
    AST_RELEASE: assert property (
        monitor_reset_req && above_s && !below_s |=> !monitor_reset_req)
        else $error("reset held after supply recovered");

    // Status flag
    AST_FLAG_SET: assert property (
        below_s && !sys_reset |=> low_supply_flag)
        else $error("flag not set below falling threshold");
    AST_FLAG_HOLD: assert property (
        !below_s && !above_s && !sys_reset |=> $stable(low_supply_flag))
        else $error("flag changed inside hysteresis band");
    AST_FLAG_CLR_ABOVE: assert property (
        above_s && !below_s |=> !low_supply_flag)
        else $error("flag not cleared above rising threshold");
    AST_FLAG_CLR: assert property (
        sys_reset |=> !low_supply_flag)
        else $error("flag not cleared by reset");
    AST_RESET_VALUES: assert property (
        $fell(rst) |-> !low_supply_flag && !monitor_reset_req && !cfg_locked)
        else $error("state not cleared by reset");
    AST_NO_IRQ: assert property (
        !monitor_irq)
        else $error("interrupt raised");

    // Configuration
    AST_LEVEL_FOLLOWS: assert property (
        cfg_wr && !sys_reset |=>
            trip_level_out == $past(cfg_wdata.trip_level_select))
        else $error("trip level not applied");
    AST_LOW_LEVEL_AFTER_RESET: assert property (
        $fell(rst) |-> !trip_level_out && !cfg_rdata.trip_level_select)
        else $error("low reset level not in use after reset");
    AST_WRITE_ONCE: assert property (
        cfg_locked && cfg_wr |=> $stable(cfg_rdata.monitor_power_disable) &&
            $stable(cfg_rdata.monitor_stop_enable))
        else $error("write-once field changed");
    AST_LOCK_STAYS: assert property (
        cfg_locked |=> cfg_locked)
        else $error("write lock dropped");
    AST_REWRITE: assert property (
        cfg_wr |=> cfg_rdata.monitor_reset_disable ==
            $past(cfg_wdata.monitor_reset_disable))
        else $error("reset-disable write lost");

    COV_TRIP: cover property (resets_on && below_s ##1 monitor_reset_req);
    COV_RELEASE: cover property ($fell(monitor_reset_req));
    COV_RAISE: cover property (st_ff.state == SDMC_CHECK ##[1:8]
        monitor_reset_req);
    COV_POLL: cover property (cfg_rdata.monitor_reset_disable &&
        low_supply_flag);
    COV_RAISE_PASS: cover property (st_ff.state == SDMC_CHECK ##1
        st_ff.state == SDMC_NORMAL && !monitor_reset_req);
endmodule : sdmc_supply_drop_monitor_ctl
`default_nettype wire

// ==== common/sdmc_pkg.sv ====
/*
 * Shared types and constants of the supply drop monitor control block.
 * Assumes a single 50 MHz clock and synchronous active-high reset.
 */
package sdmc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Time after a raise of the trip level for the comparator to settle
    localparam int SETTLE_NS = 100;
    localparam int SETTLE_CYC_I = (SETTLE_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam logic [3:0] SETTLE_CYC = SETTLE_CYC_I[3:0];

    // Reset values of the configuration fields
    localparam logic RST_POWER_DISABLE = 1'h0;
    localparam logic RST_STOP_ENABLE = 1'h0;
    localparam logic RST_RESET_DISABLE = 1'h0;
    localparam logic RST_TRIP_LEVEL = 1'h0;

    // Trip level encodings
    localparam logic LEVEL_LOW_RESET = 1'h0;
    localparam logic LEVEL_HIGH_DETECT = 1'h1;

    typedef struct packed {
        logic monitor_power_disable;
        logic monitor_stop_enable;
        logic monitor_reset_disable;
        logic trip_level_select;
    } sdmc_cfg_s;

    typedef struct packed {
        logic below_fall;
        logic above_rise;
    } sdmc_cmp_s;

    typedef enum logic [2:0] {
        SDMC_NORMAL = 3'h1,
        SDMC_CHECK = 3'h2,
        SDMC_RESET = 3'h4
    } sdmc_state_e;
endpackage : sdmc_pkg

// ==== tb/sdmc_supply_drop_monitor_ctl_tb_top.sv ====
/*
 * Self-checking bench of the supply drop monitor control block.
 * Assumes the design package is compiled first; the bench drives all ports.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module sdmc_supply_drop_monitor_ctl_tb_top;
    import sdmc_pkg::*;
    logic clk, rst, sys_reset, cfg_wr, wait_mode, stop_mode;
    sdmc_cfg_s cfg_wdata, cfg_rdata, cfg;
    sdmc_cmp_s cmp_async;
    logic cfg_locked, low_supply_flag, monitor_reset_req;
    logic monitor_analog_en, trip_level_out, monitor_irq;
    logic [9:0] exp_q[$];
    logic [16:0] lfsr;
    int errors, num_checks;
    wire logic [9:0] obs = {cfg_rdata, cfg_locked, low_supply_flag,
        monitor_reset_req, monitor_analog_en, trip_level_out, monitor_irq};

    sdmc_supply_drop_monitor_ctl uut (.clk(clk), .rst(rst),
        .sys_reset(sys_reset), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .cmp_async(cmp_async),
        .cfg_rdata(cfg_rdata), .cfg_locked(cfg_locked),
        .low_supply_flag(low_supply_flag),
        .monitor_reset_req(monitor_reset_req),
        .monitor_analog_en(monitor_analog_en),
        .trip_level_out(trip_level_out), .monitor_irq(monitor_irq));

    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    function automatic logic [9:0] ex(sdmc_cfg_s c, logic lk, logic fl,
        logic rq, logic an);
        return {c, lk, fl, rq, an, c.trip_level_select, 1'h0};
    endfunction : ex

    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction : lfsr_next

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Write strobe then random junk on the data lines to prove gating
    task automatic wr(input sdmc_cfg_s d);
        cfg_wdata = d;
        cfg_wr = 1'h1;
        cyc(1);
        cfg_wr = 1'h0;
        lfsr = lfsr_next(lfsr);
        cfg_wdata = lfsr[3:0];
        cyc(3);
    endtask : wr

    // Three edges: two synchroniser flops and the state register
    task automatic cmp(input logic b, input logic a);
        cmp_async = '{below_fall: b, above_rise: a};
        cyc(3);
    endtask : cmp

    task automatic do_reset();
        rst = 1'h1;
        cyc(20);
        rst = 1'h0;
        cyc(1);
    endtask : do_reset

    initial
    begin
        forever
        begin
            wait (exp_q.size() > 0);
            `CHK(obs, exp_q[0])
            void'(exp_q.pop_front());
        end
    end

    initial
    begin : main
        int i;
        {rst, sys_reset, cfg_wr, wait_mode, stop_mode} = 5'h10;
        cfg_wdata = '0;
        cmp_async = '{below_fall: 1'h0, above_rise: 1'h1};
        lfsr = 17'h11705;
        do_reset();
        cfg = '0;
        exp_q.push_back(ex(cfg, 0, 0, 0, 1));
        wait_mode = lfsr[0];
        cmp(1, 0);
        exp_q.push_back(ex(cfg, 0, 1, 1, 1));
        cmp(0, 0);
        exp_q.push_back(ex(cfg, 0, 1, 1, 1));
        sys_reset = 1'h1;
        cyc(1);
        sys_reset = 1'h0;
        cyc(1);
        exp_q.push_back(ex(cfg, 0, 0, 1, 1));
        cmp(0, 1);
        exp_q.push_back(ex(cfg, 0, 0, 0, 1));
        cfg = '{1'h0, 1'h1, 1'h1, 1'h0};
        wr(cfg);
        exp_q.push_back(ex(cfg, 1, 0, 0, 1));
        cmp(1, 0);
        exp_q.push_back(ex(cfg, 1, 1, 0, 1));
        stop_mode = 1'h1;
        wr('{1'h1, 1'h0, 1'h0, 1'h0});
        cfg.monitor_reset_disable = 1'h0;
        exp_q.push_back(ex(cfg, 1, 1, 1, 1));
        cmp(0, 1);
        exp_q.push_back(ex(cfg, 1, 0, 0, 1));
        cmp(0, 0);
        cfg.trip_level_select = 1'h1;
        wr(cfg);
        // Settle window is short; twenty cycles is ample margin
        for (i = 0; i < 20 && monitor_reset_req !== 1'h1; i++)
            cyc(1);
        exp_q.push_back(ex(cfg, 1, 0, 1, 1));
        {stop_mode, wait_mode} = 2'h0;
        cmp(0, 1);
        exp_q.push_back(ex(cfg, 1, 0, 0, 1));
        // Raising the level with the supply above it must not reset
        cfg.trip_level_select = 1'h0;
        wr(cfg);
        cfg.trip_level_select = 1'h1;
        wr(cfg);
        cyc(6);
        exp_q.push_back(ex(cfg, 1, 0, 0, 1));
        do_reset();
        cfg = '0;
        stop_mode = 1'h1;
        cmp(1, 0);
        exp_q.push_back(ex(cfg, 0, 0, 0, 0));
        stop_mode = 1'h0;
        cmp(0, 1);
        cfg = '{1'h1, 1'h0, 1'h0, 1'h0};
        wr(cfg);
        cmp(1, 0);
        exp_q.push_back(ex(cfg, 1, 0, 0, 0));
        cyc(1);
        if (i == 20)
            errors++;
        complete_run();
    end
endmodule : sdmc_supply_drop_monitor_ctl_tb_top
`default_nettype wire
